// ### verilog/ppl_probe.sv
// Purpose: one probe channel: edge detect and position capture
// Assumes: trigger inputs synchronous to core_clk
// Notes: single mode latches first edge only until probe is re-enabled
`timescale 1ns/1ps
module ppl_probe #(
  parameter int unsigned POS_W = 32
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire ppl_pkg::ppl_probe_cfg_t cfg,
  input wire logic di_trig,
  input wire logic index_pulse,
  input wire logic [POS_W-1:0] position,
  output ppl_pkg::ppl_probe_stat_t stat,
  output logic [POS_W-1:0] rise_pos_q,
  output logic [POS_W-1:0] fall_pos_q
);
  logic trig;
  logic trig_q;
  logic rise_ev;
  logic fall_ev;
  logic rise_held_q;
  logic fall_held_q;
  logic en_q;

  // Index pulse marks the single-turn zero crossing on absolute encoders
  assign trig = cfg.use_index ? index_pulse : di_trig;
  assign rise_ev = cfg.enable & cfg.rise_en & trig & ~trig_q;
  assign fall_ev = cfg.enable & cfg.fall_en & ~trig & trig_q;

  // Previous trigger level for edge detection
  always_ff @(posedge core_clk)
  begin
    if (rst)
      trig_q <= 1'b0;
    else
      trig_q <= trig;
  end

  // Enable history; a fresh enable re-arms single mode
  always_ff @(posedge core_clk)
  begin
    if (rst)
      en_q <= 1'b0;
    else
      en_q <= cfg.enable;
  end

  // Rising capture; single mode keeps the first value only
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rise_held_q <= 1'b0;
      rise_pos_q <= POS_W'(ppl_pkg::POS_RESET);
    end
    else if (rise_ev && (cfg.continuous || !rise_held_q))
    begin
      rise_held_q <= 1'b1;
      rise_pos_q <= position;
    end
    else if (!cfg.enable || (cfg.enable && !en_q))
      rise_held_q <= 1'b0; // Set wins: the event branch is tested first
  end

  // Falling capture, same shape as rising
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      fall_held_q <= 1'b0;
      fall_pos_q <= POS_W'(ppl_pkg::POS_RESET);
    end
    else if (fall_ev && (cfg.continuous || !fall_held_q))
    begin
      fall_held_q <= 1'b1;
      fall_pos_q <= position;
    end
    else if (!cfg.enable || (cfg.enable && !en_q))
      fall_held_q <= 1'b0;
  end

  assign stat.enabled = cfg.enable;
  assign stat.rise_held = rise_held_q;
  assign stat.fall_held = fall_held_q;

  // Held flag follows a rising edge within one cycle
  property p_rise_set;
    @(posedge core_clk) disable iff (rst)
      rise_ev |=> rise_held_q;
  endproperty
  a_rise_set: assert property (p_rise_set)
    else $error("rise flag not set after edge");

  property p_fall_pos;
    @(posedge core_clk) disable iff (rst)
      (fall_ev && !fall_held_q) |=> (fall_pos_q == $past(position));
  endproperty
  a_fall_pos: assert property (p_fall_pos)
    else $error("falling position not captured");

  property p_gate;
    @(posedge core_clk) disable iff (rst)
      (!cfg.rise_en && !rise_held_q) |=> !rise_held_q;
  endproperty
  a_gate: assert property (p_gate)
    else $error("rise captured while gated off");

  property p_off_clear;
    @(posedge core_clk) disable iff (rst)
      (!cfg.enable ##1 !cfg.enable) |-> (!rise_held_q && !fall_held_q);
  endproperty
  a_off_clear: assert property (p_off_clear)
    else $error("flags held while probe off");

  property p_index_src;
    @(posedge core_clk) disable iff (rst)
      (cfg.use_index && cfg.enable && cfg.rise_en && !rise_held_q
       && index_pulse && !trig_q) |=> rise_held_q;
  endproperty
  a_index_src: assert property (p_index_src)
    else $error("index pulse did not trigger");

  property p_single;
    @(posedge core_clk) disable iff (rst)
      (!cfg.continuous && rise_held_q && cfg.enable && en_q)
        |=> $stable(rise_pos_q);
  endproperty
  a_single: assert property (p_single)
    else $error("single mode overwrote value");

  c_rise: cover property (@(posedge core_clk) disable iff (rst) rise_ev);
  c_fall: cover property (@(posedge core_clk) disable iff (rst) fall_ev);
  c_both: cover property (@(posedge core_clk) disable iff (rst)
    rise_held_q && fall_held_q);
endmodule

// ### verilog/ppl_pkg.sv
// Purpose: shared constants and types for the position probe latch
// Assumes: one clock, synchronous active-high reset
// Notes: control word layout per probe: enable, mode, source, rise, fall
package ppl_pkg;
  localparam int unsigned CTRL_W = 16;
  localparam int unsigned POS_W = 32;
  // Control word field positions, probe one low byte, probe two high byte
  localparam int unsigned C_EN1 = 0;
  localparam int unsigned C_MODE1 = 1;
  localparam int unsigned C_SRC1 = 2;
  localparam int unsigned C_RISE1 = 4;
  localparam int unsigned C_FALL1 = 5;
  localparam int unsigned C_EN2 = 8;
  localparam int unsigned C_MODE2 = 9;
  localparam int unsigned C_SRC2 = 10;
  localparam int unsigned C_RISE2 = 12;
  localparam int unsigned C_FALL2 = 13;
  // Writable control bits; 14 and 15 and the gaps are dropped
  localparam logic [15:0] CTRL_MASK = 16'h3737;
  // Status word field positions
  localparam int unsigned S_EN1 = 0;
  localparam int unsigned S_RISE1 = 1;
  localparam int unsigned S_FALL1 = 2;
  localparam int unsigned S_EN2 = 8;
  localparam int unsigned S_RISE2 = 9;
  localparam int unsigned S_FALL2 = 10;
  localparam logic [15:0] STAT_RESET = 16'h0000;
  localparam logic [31:0] POS_RESET = 32'h0000_0000;

  // Per-probe control fields
  typedef struct packed {
    logic enable;
    logic continuous;
    logic use_index;
    logic rise_en;
    logic fall_en;
  } ppl_probe_cfg_t;

  // Per-probe captured state
  typedef struct packed {
    logic enabled;
    logic rise_held;
    logic fall_held;
  } ppl_probe_stat_t;
endpackage

// ### verilog/ppl_top.sv
// Purpose: two-probe position latch with control and status words
// Assumes: control word is held by process data, sampled every cycle
// Notes: status word is combinational from probe state, read-only
`timescale 1ns/1ps
module ppl_top #(
  parameter int unsigned POS_W = ppl_pkg::POS_W
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [15:0] probe_ctrl,
  input wire logic [1:0] di_trig,
  input wire logic index_pulse,
  input wire logic [POS_W-1:0] position,
  output logic [15:0] probe_latch_state,
  output logic [POS_W-1:0] p1_rise_pos,
  output logic [POS_W-1:0] p1_fall_pos,
  output logic [POS_W-1:0] p2_rise_pos,
  output logic [POS_W-1:0] p2_fall_pos
);
  logic [15:0] ctrl;
  ppl_pkg::ppl_probe_cfg_t cfg1;
  ppl_pkg::ppl_probe_cfg_t cfg2;
  ppl_pkg::ppl_probe_stat_t st1;
  ppl_pkg::ppl_probe_stat_t st2;

  // Drop unused control bits so they cannot steer anything
  assign ctrl = probe_ctrl & ppl_pkg::CTRL_MASK;

  // Field split of the control word
  assign cfg1 = '{enable: ctrl[ppl_pkg::C_EN1],
                  continuous: ctrl[ppl_pkg::C_MODE1],
                  use_index: ctrl[ppl_pkg::C_SRC1],
                  rise_en: ctrl[ppl_pkg::C_RISE1],
                  fall_en: ctrl[ppl_pkg::C_FALL1]};
  assign cfg2 = '{enable: ctrl[ppl_pkg::C_EN2],
                  continuous: ctrl[ppl_pkg::C_MODE2],
                  use_index: ctrl[ppl_pkg::C_SRC2],
                  rise_en: ctrl[ppl_pkg::C_RISE2],
                  fall_en: ctrl[ppl_pkg::C_FALL2]};

  ppl_probe #(.POS_W(POS_W)) u_p1 (
    .core_clk(core_clk),
    .rst(rst),
    .cfg(cfg1),
    .di_trig(di_trig[0]),
    .index_pulse(index_pulse),
    .position(position),
    .stat(st1),
    .rise_pos_q(p1_rise_pos),
    .fall_pos_q(p1_fall_pos)
  );

  ppl_probe #(.POS_W(POS_W)) u_p2 (
    .core_clk(core_clk),
    .rst(rst),
    .cfg(cfg2),
    .di_trig(di_trig[1]),
    .index_pulse(index_pulse),
    .position(position),
    .stat(st2),
    .rise_pos_q(p2_rise_pos),
    .fall_pos_q(p2_fall_pos)
  );

  // Status assembly; every bit not listed stays zero
  always_comb
  begin
    probe_latch_state = ppl_pkg::STAT_RESET;
    probe_latch_state[ppl_pkg::S_EN1] = st1.enabled;
    probe_latch_state[ppl_pkg::S_RISE1] = st1.rise_held;
    probe_latch_state[ppl_pkg::S_FALL1] = st1.fall_held;
    probe_latch_state[ppl_pkg::S_EN2] = st2.enabled;
    probe_latch_state[ppl_pkg::S_RISE2] = st2.rise_held;
    probe_latch_state[ppl_pkg::S_FALL2] = st2.fall_held;
  end

  property p_unused_zero;
    @(posedge core_clk) disable iff (rst)
      (probe_latch_state & ~16'h0707) == 16'h0000;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused status bit set");

  property p_en_mirror;
    @(posedge core_clk) disable iff (rst)
      probe_latch_state[ppl_pkg::S_EN2] == probe_ctrl[ppl_pkg::C_EN2];
  endproperty
  a_en_mirror: assert property (p_en_mirror)
    else $error("probe two enable not mirrored");

  c_p2_rise: cover property (@(posedge core_clk) disable iff (rst)
    probe_latch_state[9]);
endmodule

// ### verif/ppl_trig_model.sv
// Purpose: far-side model of the probe digital inputs and encoder index
// Assumes: bench requests levels just after a rising edge
// Notes: lvl[1:0] are the digital triggers, lvl[2] the index pulse
`timescale 1ns/1ps
module ppl_trig_model (
  input wire logic core_clk,
  input wire logic [2:0] lvl,
  output logic [1:0] di_trig,
  output logic index_pulse
);
  // Registered so every edge reaches the latch synchronous to core_clk
  always_ff @(posedge core_clk)
  begin
    di_trig <= lvl[1:0];
    index_pulse <= lvl[2];
  end
endmodule

// ### verif/position_probe_latch_tb.sv
// Purpose: self-checking bench for the two-probe position latch
// Assumes: status reads combinationally, flags update at the trigger edge
// Notes: one task per scenario; trigger path adds one model register
`timescale 1ns/1ps
module position_probe_latch_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] ctrl = 16'h0000;
  logic [2:0] lvl = 3'h0;
  logic [31:0] pos = 32'h0000_0000;
  logic [1:0] di;
  logic idx;
  logic [15:0] st;
  logic [31:0] r1, f1, r2, f2;
  int fail_count = 0;
  int comparisons = 0;

  // 20 MHz core clock
  initial
  begin
    forever #25 core_clk = ~core_clk;
  end

  ppl_top uut (.core_clk(core_clk), .rst(rst), .probe_ctrl(ctrl),
    .di_trig(di), .index_pulse(idx), .position(pos),
    .probe_latch_state(st), .p1_rise_pos(r1), .p1_fall_pos(f1),
    .p2_rise_pos(r2), .p2_fall_pos(f2));

  ppl_trig_model src (.core_clk(core_clk), .lvl(lvl), .di_trig(di),
    .index_pulse(idx));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Control is a level input; one extra edge lets it settle
  task automatic cfg(input logic [15:0] c);
    @(posedge core_clk);
    ctrl <= c;
    @(posedge core_clk);
    #1;
  endtask

  // Model registers the level, the latch sees the edge one cycle later
  task automatic step(input logic [2:0] l, input logic [31:0] p);
    @(posedge core_clk);
    lvl <= l;
    pos <= p;
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  task automatic t_reset();
    #1;
    chk({16'h0000, st}, 32'h0000_0000);
    chk(r1 | f1 | r2 | f2, 32'h0000_0000);
    cfg(16'hC101);
    chk({16'h0000, st}, 32'h0000_0101);
  endtask

  // Continuous mode on probe two, both edges gated on
  task automatic t_p2_edges();
    cfg(16'h3300);
    step(3'h2, 32'h0000_1234);
    chk({16'h0000, st}, 32'h0000_0300);
    chk(r2, 32'h0000_1234);
    step(3'h0, 32'h0000_5678);
    chk({16'h0000, st}, 32'h0000_0700);
    chk(f2, 32'h0000_5678);
    step(3'h2, 32'h0000_9ABC);
    chk(r2, 32'h0000_9ABC);
  endtask

  // Falling edge gated off: only the rising flag may set
  task automatic t_edge_off();
    cfg(16'h0000);
    chk({16'h0000, st}, 32'h0000_0000);
    cfg(16'h1100);
    step(3'h0, 32'h0000_0011);
    chk({16'h0000, st}, 32'h0000_0100);
    chk(f2, 32'h0000_5678);
    step(3'h2, 32'h0000_0022);
    chk({16'h0000, st}, 32'h0000_0300);
    chk(r2, 32'h0000_0022);
    // Single mode: a second rising edge must not overwrite the first value
    step(3'h0, 32'h0000_0033);
    step(3'h2, 32'h0000_0044);
    chk(r2, 32'h0000_0022);
    chk({16'h0000, st}, 32'h0000_0300);
  endtask

  // Reset in mid-run drops held flags and positions; enables follow ctrl
  task automatic t_mid_reset();
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk({16'h0000, st}, 32'h0000_0001);
    chk(r1 | f1, 32'h0000_0000);
    step(3'h5, 32'h0000_00DD);
    chk({16'h0000, st}, 32'h0000_0003);
    chk(r1, 32'h0000_00DD);
  endtask

  // Probe one on the index source ignores its digital input
  task automatic t_index();
    cfg(16'h0000);
    cfg(16'h0037);
    step(3'h4, 32'h0000_00AA);
    chk({16'h0000, st}, 32'h0000_0003);
    chk(r1, 32'h0000_00AA);
    step(3'h5, 32'h0000_00BB);
    chk(r1, 32'h0000_00AA);
    step(3'h1, 32'h0000_00CC);
    chk({16'h0000, st}, 32'h0000_0007);
    chk(f1, 32'h0000_00CC);
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Whole sequence needs well under 200 cycles
  initial
  begin
    repeat (2000) @(posedge core_clk);
    fail_count++;
    conclude();
  end

  initial
  begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_p2_edges();
    t_edge_off();
    t_index();
    t_mid_reset();
    conclude();
  end
endmodule
